// ---- rtl/timer2_reload_compare_pwm.sv ----
// Reload/compare timer with PWM pins, gating and single shot, behind an AHB-Lite slave
`timescale 1ns/100ps
`include "timer2_defines.svh"
module timer2_reload_compare_pwm
	import timer2_pkg::*;
#(
	parameter int TWO_PINS = 1
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        prim_pin_in,
	output logic             prim_pin_out,
	output logic             prim_pin_oe,
	output logic             sec_pin_out,
	output logic             sec_pin_oe,
	output logic             timer_out_clock,
	output logic             irq_request
);

	// Register state
	logic [15:0] ctrl_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] count_vis;
	logic [15:0] reload_q;
	logic [15:0] compare_q;
	logic [7:0]  hb_count_q;
	logic        ss_q;
	logic        ovf_flag_q;
	logic        cmp_flag_q;
	logic        ev_q;
	logic        toggle_q;
	logic [1:0]  oe_prev_q;
	logic [1:0]  pol_eff_q;

	// Bus state
	logic        wr_q;
	logic        rd_q;
	logic [4:0]  addr_q;
	logic [31:0] hrdata_q;
	logic        bus_hit;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_count;
	logic        wr_reload;
	logic        wr_compare;

	// Timing and events
	mode_t       mode;
	logic        split;
	logic        pre_tick;
	logic        pin_s;
	logic        pin_d_q;
	logic        pin_edge;
	logic        gated_mode;
	logic        gate_block;
	logic        run_en;
	logic        count_tick;
	logic [15:0] top_v;
	logic [15:0] reload_eff;
	logic [15:0] compare_eff;
	logic        cmp_in_range;
	logic        ovf_ev;
	logic        cmp_ev;

	// Decoded control fields
	logic        run;
	logic        gate_en;
	logic [1:0]  oe;
	logic [1:0]  pol;
	logic [1:0]  ccf;

	assign run     = ctrl_q[`T2_RUN];
	assign gate_en = ctrl_q[`T2_GATE];
	assign oe      = ctrl_q[`T2_OE];
	assign pol     = ctrl_q[`T2_POL];
	assign ccf     = ctrl_q[`T2_CCF];

	// Operating mode from mode select, counter select and function field
	assign mode  = decode_mode(ctrl_q[`T2_MD], ctrl_q[`T2_CT], ccf);
	assign split = (mode == MODE_SPLIT);

	timer2_prescaler #(
		.SEL_W (3),
		.CNT_W (7)
	) u_prescaler (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.ratio_sel (ctrl_q[`T2_DIV]),
		.tick      (pre_tick)
	);

	timer2_pin_sync #(
		.W (1)
	) u_pin_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (prim_pin_in),
		.sync_out (pin_s)
	);

	// Delayed copy of the synchronised pin for edge detection
	always_ff @(posedge mclk) begin
		if (!rst_n)
			pin_d_q <= 1'b0;
		else
			pin_d_q <= pin_s;
	end

	// Function field picks rising, falling or both edges
	always_comb begin
		case (ccf)
			2'h1:    pin_edge = pin_s & ~pin_d_q;
			2'h2:    pin_edge = ~pin_s & pin_d_q;
			2'h3:    pin_edge = pin_s ^ pin_d_q;
			default: pin_edge = 1'b0;
		endcase
	end

	// Primary pin becomes a gate only when its output is off
	assign gated_mode = ~oe[0] & gate_en;
	assign gate_block = gated_mode & (pin_s == pol[0]);
	assign run_en     = run | ss_q;

	// Count source: prescaled clock for the timer and split modes, pin edges for the counter; capture mode does not count
	always_comb begin
		case (mode)
			MODE_TIMER16:   count_tick = run_en & ~gate_block & pre_tick;
			MODE_SPLIT:     count_tick = run_en & ~gate_block & pre_tick;
			MODE_COUNTER16: count_tick = run_en & pin_edge;
			default:        count_tick = 1'b0;
		endcase
	end

	// Split modes run the low byte alone, so limits shrink to eight bits
	assign top_v       = split ? `T2_TOP8 : `T2_TOP16;
	assign reload_eff  = split ? {8'h00, reload_q[7:0]} : reload_q;
	assign compare_eff = split ? {8'h00, compare_q[7:0]} : compare_q;

	// A compare value below the reload point is never matched
	assign cmp_in_range = (compare_eff >= reload_eff);
	assign ovf_ev       = count_tick & (count_q == top_v);
	assign cmp_ev       = count_tick & (mode != MODE_COUNTER16) & cmp_in_range
	                      & (count_q == compare_eff);

	// Next count: software write beats overflow reload beats increment
	always_comb begin
		if (wr_count)
			count_d = hwdata[15:0];
		else if (ovf_ev)
			count_d = reload_eff;
		else if (count_tick)
			count_d = count_q + 16'h0001;
		else
			count_d = count_q;
	end

	// High byte is forced to zero in the split modes
	always_ff @(posedge mclk) begin
		if (!rst_n)
			count_q <= `T2_COUNT_RST;
		else
			count_q <= split ? {8'h00, count_d[7:0]} : count_d;
	end

	// Masked count for AST_HOLD (reads return count_q); entering split mode clears a stale high byte without a tick
	assign count_vis = split ? {8'h00, count_q[7:0]} : count_q;

	// High-byte counter of the split counter mode
	always_ff @(posedge mclk) begin
		if (!rst_n)
			hb_count_q <= 8'h00;
		else if (split && ctrl_q[`T2_CT] && run_en && pin_edge)
			hb_count_q <= hb_count_q + 8'h01;
	end

	// Reload register
	always_ff @(posedge mclk) begin
		if (!rst_n)
			reload_q <= `T2_RELOAD_RST;
		else if (wr_reload)
			reload_q <= hwdata[15:0];
	end

	// Compare register; its high byte captures the low count in split capture mode
	always_ff @(posedge mclk) begin
		if (!rst_n)
			compare_q <= `T2_COMPARE_RST;
		else if (wr_compare)
			compare_q <= hwdata[15:0];
		else if (split && !ctrl_q[`T2_CT] && run_en && pin_edge)
			compare_q[15:8] <= count_q[7:0];
	end

	// Control register; the single-shot bit lives in its own flop
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctrl_q <= `T2_CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= hwdata[15:0];
	end

	// Single shot: a software set wins over the clear at overflow
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ss_q <= 1'b0;
		else if (wr_ctrl && hwdata[`T2_SS])
			ss_q <= 1'b1;
		else if (ovf_ev)
			ss_q <= 1'b0;
	end

	// Sticky flags: hardware set wins over a software clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ovf_flag_q <= 1'b0;
			cmp_flag_q <= 1'b0;
		end else begin
			ovf_flag_q <= ovf_ev | (wr_status ? hwdata[`T2_ST_OVF] : ovf_flag_q);
			cmp_flag_q <= cmp_ev | (wr_status ? hwdata[`T2_ST_CMP] : cmp_flag_q);
		end
	end

	// Output clock toggles two cycles after an event; a coincident pair is one event
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ev_q     <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			ev_q     <= ovf_ev | cmp_ev;
			toggle_q <= toggle_q ^ ev_q;
		end
	end

	// Polarity is latched only on an enable rising edge so a running pin never glitches
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			oe_prev_q <= 2'h0;
			pol_eff_q <= 2'h0;
		end else begin
			oe_prev_q <= oe;
			for (int n = 0; n < 2; n++) begin
				if (oe[n] && !oe_prev_q[n])
					pol_eff_q[n] <= pol[n];
			end
		end
	end

	// Pin drive; the secondary pin does not exist in one-pin builds
	assign prim_pin_oe     = oe[0];
	assign prim_pin_out    = toggle_q ^ pol_eff_q[0];
	assign sec_pin_oe      = (TWO_PINS != 0) & oe[1];
	assign sec_pin_out     = (TWO_PINS != 0) & (toggle_q ^ pol_eff_q[1]);
	assign timer_out_clock = toggle_q;
	assign irq_request     = ctrl_q[`T2_IE] & (ovf_flag_q | cmp_flag_q);

	// Address phase capture; reads take one wait state so a write just before is seen
	assign bus_hit = hsel & htrans[1] & hready;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 5'h00;
		end else begin
			wr_q <= bus_hit & hwrite;
			rd_q <= bus_hit & ~hwrite;
			if (bus_hit)
				addr_q <= haddr[4:0];
		end
	end

	// Write strobes in the data phase; unmapped writes are dropped
	assign wr_ctrl    = wr_q & (addr_q == `T2_OFF_CTRL);
	assign wr_status  = wr_q & (addr_q == `T2_OFF_STATUS);
	assign wr_count   = wr_q & (addr_q == `T2_OFF_COUNT);
	assign wr_reload  = wr_q & (addr_q == `T2_OFF_RELOAD);
	assign wr_compare = wr_q & (addr_q == `T2_OFF_COMPARE);

	// Read data captured during the wait cycle; unmapped reads give zero
	always_ff @(posedge mclk) begin
		if (!rst_n)
			hrdata_q <= 32'h0000_0000;
		else if (rd_q) begin
			case (addr_q)
				`T2_OFF_CTRL:    hrdata_q <= {16'h0000, ctrl_q[15:2], ss_q, ctrl_q[0]};
				`T2_OFF_STATUS:  hrdata_q <= {16'h0000, hb_count_q, 6'h00, cmp_flag_q, ovf_flag_q};
				`T2_OFF_COUNT:   hrdata_q <= {16'h0000, count_q};
				`T2_OFF_RELOAD:  hrdata_q <= {16'h0000, reload_q};
				`T2_OFF_COMPARE: hrdata_q <= {16'h0000, compare_q};
				default:         hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = ~rd_q;
	assign hresp     = 1'b0;

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_OVF_RELOAD: assert property (ovf_ev && !wr_count && !split |=> count_q == $past(reload_q))
		else $error("overflow did not load reload value");
	AST_OVF_FLAG: assert property (ovf_ev |=> ovf_flag_q)
		else $error("overflow flag not set");
	AST_FLAG_STICKY: assert property (ovf_flag_q && !wr_status |=> ovf_flag_q)
		else $error("overflow flag dropped without software");
	AST_IRQ: assert property (ctrl_q[`T2_IE] && $rose(cmp_flag_q) |-> irq_request)
		else $error("interrupt request missing");
	AST_HOLD: assert property (!run && !ss_q && !wr_count && !wr_ctrl |=> $stable(count_vis))
		else $error("count moved while stopped");
	AST_CMP_RANGE: assert property (!cmp_in_range |-> !cmp_ev ##1 (!ev_q || $past(ovf_ev)))
		else $error("compare matched outside counting range");
	AST_TOGGLE: assert property (ev_q |=> toggle_q != $past(toggle_q))
		else $error("output clock did not toggle after event");
	AST_SS_CLEAR: assert property (ovf_ev && !(wr_ctrl && hwdata[`T2_SS]) |=> !ss_q)
		else $error("single shot not cleared at overflow");
	AST_SPLIT_HIGH: assert property (split && $past(split) |-> count_q[15:8] == 8'h00)
		else $error("split mode counter high byte not zero");
	AST_GATE: assert property (gated_mode && pin_s == pol[0] |-> !count_tick)
		else $error("timer advanced while gated");
	AST_POL_LATCH: assert property ($rose(oe[0]) |=> pol_eff_q[0] == $past(pol[0]))
		else $error("polarity not taken on enable rise");

endmodule : timer2_reload_compare_pwm

// ---- rtl/timer2_defines.svh ----
// Register offsets, control field positions and reset values of the reload/compare timer
`ifndef TIMER2_DEFINES_SVH
`define TIMER2_DEFINES_SVH

// Byte offsets on the register bus
`define T2_OFF_CTRL     5'h00
`define T2_OFF_STATUS   5'h04
`define T2_OFF_COUNT    5'h08
`define T2_OFF_RELOAD   5'h0c
`define T2_OFF_COMPARE  5'h10

// Control register fields
`define T2_RUN          0
`define T2_SS           1
`define T2_GATE         2
`define T2_RELEN        3
`define T2_OE           5:4
`define T2_POL          7:6
`define T2_DIV          10:8
`define T2_IE           11
`define T2_MD           12
`define T2_CT           13
`define T2_CCF          15:14

// Status register fields
`define T2_ST_OVF       0
`define T2_ST_CMP       1
`define T2_ST_HB        15:8

// Reset values
`define T2_CTRL_RST     16'h0000
`define T2_COUNT_RST    16'h0000
`define T2_RELOAD_RST   16'h0000
`define T2_COMPARE_RST  16'h0000

// Counter limits
`define T2_TOP16        16'hffff
`define T2_TOP8         16'h00ff

`endif

// ---- rtl/timer2_pkg.sv ----
// Types and mode decoding shared by the reload/compare timer files
package timer2_pkg;

	typedef enum logic [1:0] {
		MODE_TIMER16,
		MODE_COUNTER16,
		MODE_CAPTURE16,
		MODE_SPLIT
	} mode_t;

	// Mode select, counter/timer select and function field to operating mode
	function automatic mode_t decode_mode(input logic md, input logic ct, input logic [1:0] ccf);
		mode_t m;
		m = MODE_TIMER16;
		if (md)
			m = MODE_SPLIT;
		else if (ccf != 2'h0)
			m = ct ? MODE_COUNTER16 : MODE_CAPTURE16;
		return m;
	endfunction : decode_mode

endpackage : timer2_pkg

// ---- rtl/timer2_pin_sync.sv ----
// Two-flop synchroniser for pin levels entering the timer clock domain
`timescale 1ns/100ps
module timer2_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : timer2_pin_sync

// ---- rtl/timer2_prescaler.sv ----
// Free-running prescaler giving one tick every 2^sel system clocks
`timescale 1ns/100ps
module timer2_prescaler #(
	parameter int SEL_W = 3,
	parameter int CNT_W = 7
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [SEL_W-1:0] ratio_sel,
	output logic                  tick
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] mask;

	// Runs freely so a ratio change takes effect within one period
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	// Low bits all zero marks the divided clock edge
	always_comb begin
		mask = CNT_W'((32'h1 << ratio_sel) - 32'h1);
		tick = ((cnt_q & mask) == '0);
	end

endmodule : timer2_prescaler

// ---- verification/timer2_pin_partner.sv ----
// Far-side model: external gate source on the primary pin and a load on the secondary pin
`timescale 1ns/100ps
module timer2_pin_partner (
	input  wire logic mclk,
	input  wire logic gate_level,
	input  wire logic prim_pin_out,
	input  wire logic prim_pin_oe,
	input  wire logic sec_pin_out,
	input  wire logic sec_pin_oe,
	output logic      prim_wire,
	output int        sec_edges
);
	logic last_q = 1'b0;

	// Pin level: the device wins while it drives, else the external source sets it
	assign prim_wire = prim_pin_oe ? prim_pin_out : gate_level;

	// The load counts level changes on the enabled secondary pin
	initial sec_edges = 0;
	always @(posedge mclk) begin
		last_q <= sec_pin_out;
		if (sec_pin_oe && sec_pin_out !== last_q)
			sec_edges <= sec_edges + 1;
	end
endmodule : timer2_pin_partner

// ---- verification/timer2_reload_compare_pwm_bench.sv ----
// Self-checking bench for the reload/compare timer: bus accesses, pins and gate source
`timescale 1ns/100ps
`include "timer2_defines.svh"
module timer2_reload_compare_pwm_bench;
	localparam logic [4:0] ctl = `T2_OFF_CTRL, sts = `T2_OFF_STATUS, cnt = `T2_OFF_COUNT;
	localparam logic [4:0] rld = `T2_OFF_RELOAD, cmp = `T2_OFF_COMPARE;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        gate_level = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, v, w;
	logic        hreadyout, hresp, prim_wire, prim_pin_out, prim_pin_oe, sec_pin_out, sec_pin_oe, toc, irq_request;
	int          sec_edges, e0;
	int          bad_count = 0;
	int          tests_run = 0;

	// System clock, 50 ns period
	initial forever #25 mclk = ~mclk;

	// Slave ready drives the bus ready, as with a single slave
	timer2_reload_compare_pwm DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .prim_pin_in(prim_wire), .prim_pin_out(prim_pin_out),
		.prim_pin_oe(prim_pin_oe), .sec_pin_out(sec_pin_out), .sec_pin_oe(sec_pin_oe),
		.timer_out_clock(toc), .irq_request(irq_request));

	timer2_pin_partner far_side (.mclk(mclk), .gate_level(gate_level), .prim_pin_out(prim_pin_out),
		.prim_pin_oe(prim_pin_oe), .sec_pin_out(sec_pin_out), .sec_pin_oe(sec_pin_oe),
		.prim_wire(prim_wire), .sec_edges(sec_edges));

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check_bit

	// Bounded wait for ready sampled high at a rising edge
	task automatic handshake;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			end_of_test();
		end
	endtask : handshake

	// One single transfer; read data lands in v
	task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		handshake();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		handshake();
		v = hrdata;
	endtask : bus

	// Repeated reads until the masked value shows up; a spent bound ends the run
	task automatic poll(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			bus(a, 1'b0, 32'h0);
			n++;
		end while ((v & mask) !== exp && n < 100);
		check_word(v & mask, exp);
		if ((v & mask) !== exp)
			end_of_test();
	endtask : poll

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// Reset values; the unmapped place ignores a write
		bus(5'h14, 1'b1, 32'hffff);
		for (int a = 0; a < 24; a += 4) begin
			bus(a[4:0], 1'b0, 32'h0);
			check_word(v, 32'h0);
		end
		// Run from fff0 with compare inside the range
		bus(rld, 1'b1, 32'hfff0);
		bus(cmp, 1'b1, 32'hfff8);
		bus(cnt, 1'b1, 32'hfff0);
		bus(ctl, 1'b1, 32'h0001);
		poll(sts, 32'h3, 32'h3);
		bus(ctl, 1'b1, 32'h0000);
		check_bit(irq_request, 1'b0);
		bus(ctl, 1'b1, 32'h0800);
		@(posedge mclk);
		check_bit(irq_request, 1'b1);
		bus(cnt, 1'b0, 32'h0);
		w = v;
		check_bit(w >= 32'hfff0, 1'b1);
		repeat (20) @(posedge mclk);
		bus(cnt, 1'b0, 32'h0);
		check_word(v, w);
		// Flags: software clears and sets
		bus(sts, 1'b1, 32'h0);
		bus(sts, 1'b0, 32'h0);
		check_word(v & 32'h3, 32'h0);
		bus(sts, 1'b1, 32'h1);
		bus(sts, 1'b0, 32'h0);
		check_word(v & 32'h3, 32'h1);
		// Compare below reload never matches, even while a low start count passes it
		bus(sts, 1'b1, 32'h0);
		bus(cmp, 1'b1, 32'h0010);
		bus(cnt, 1'b1, 32'h0008);
		bus(ctl, 1'b1, 32'h0001);
		repeat (20) @(posedge mclk);
		bus(ctl, 1'b1, 32'h0000);
		bus(sts, 1'b0, 32'h0);
		check_word(v & 32'h2, 32'h0);
		bus(cnt, 1'b1, 32'hfff8);
		bus(ctl, 1'b1, 32'h0001);
		poll(sts, 32'h1, 32'h1);
		bus(ctl, 1'b1, 32'h0000);
		bus(sts, 1'b0, 32'h0);
		check_word(v & 32'h2, 32'h0);
		// Every prescale code: about 130 cycles of running, tolerance for prescaler phase
		for (int d = 0; d < 8; d++) begin
			bus(cnt, 1'b1, 32'h0);
			bus(ctl, 1'b1, {21'h0, d[2:0], 8'h01});
			repeat (128) @(posedge mclk);
			bus(ctl, 1'b1, 32'h0);
			bus(cnt, 1'b0, 32'h0);
			check_bit((v + 2 - (130 >> d)) <= 4, 1'b1);
		end
		// Pins: enable both with secondary polarity set, then a late polarity change
		bus(cnt, 1'b1, 32'hfff0);
		bus(cmp, 1'b1, 32'hffff);
		bus(ctl, 1'b1, 32'h00b1);
		// Control landed at the last bus edge and polarity lands at the next one, so look after both
		repeat (2) @(posedge mclk);
		check_bit(prim_pin_oe & sec_pin_oe, 1'b1);
		check_bit(prim_pin_out, toc);
		check_bit(sec_pin_out, ~toc);
		bus(ctl, 1'b1, 32'h00f1);
		repeat (2) @(posedge mclk);
		check_bit(prim_pin_out, toc);
		bus(ctl, 1'b1, 32'h00c1);
		bus(ctl, 1'b1, 32'h00f1);
		repeat (2) @(posedge mclk);
		check_bit(prim_pin_out, ~toc);
		// Toggle counts: one per period when compare sits on overflow, two otherwise
		e0 = sec_edges;
		repeat (160) @(posedge mclk);
		check_bit((sec_edges - e0) inside {[9:11]}, 1'b1);
		bus(cmp, 1'b1, 32'hfff8);
		e0 = sec_edges;
		repeat (160) @(posedge mclk);
		check_bit((sec_edges - e0) inside {[19:21]}, 1'b1);
		// Software single pulse, then single shot together with run
		bus(ctl, 1'b1, 32'h0);
		bus(sts, 1'b1, 32'h0);
		bus(cnt, 1'b1, 32'hfff0);
		bus(ctl, 1'b1, 32'h0002);
		poll(sts, 32'h1, 32'h1);
		bus(ctl, 1'b0, 32'h0);
		check_word(v, 32'h0);
		bus(cnt, 1'b0, 32'h0);
		check_word(v, 32'hfff0);
		bus(ctl, 1'b1, 32'h0003);
		poll(ctl, 32'h2, 32'h0);
		bus(sts, 1'b1, 32'h0);
		poll(sts, 32'h1, 32'h1);
		// Gate on a low pin level, secondary pin as output
		bus(ctl, 1'b1, 32'h0);
		bus(cnt, 1'b1, 32'h0);
		bus(ctl, 1'b1, 32'h0025);
		@(posedge mclk);
		check_bit(sec_pin_oe & ~prim_pin_oe, 1'b1);
		repeat (40) @(posedge mclk);
		bus(cnt, 1'b0, 32'h0);
		check_word(v, 32'h0);
		gate_level <= 1'b1;
		repeat (40) @(posedge mclk);
		bus(cnt, 1'b0, 32'h0);
		check_bit(v != 32'h0, 1'b1);
		// Primary enable set: gate enable has no effect
		gate_level <= 1'b0;
		bus(ctl, 1'b1, 32'h0015);
		bus(cnt, 1'b0, 32'h0);
		w = v;
		repeat (40) @(posedge mclk);
		bus(cnt, 1'b0, 32'h0);
		check_bit(v != w, 1'b1);
		// Split mode hides the count high byte
		bus(ctl, 1'b1, 32'h1000);
		bus(cnt, 1'b1, 32'h1234);
		bus(cnt, 1'b0, 32'h0);
		check_word(v, 32'h0034);
		// Counter mode, each edge selection, three pin pulses
		for (int f = 1; f < 4; f++) begin
			bus(ctl, 1'b1, {16'h0, f[1:0], 14'h2001});
			bus(cnt, 1'b1, 32'h0);
			repeat (3) begin
				gate_level <= 1'b1;
				repeat (8) @(posedge mclk);
				gate_level <= 1'b0;
				repeat (8) @(posedge mclk);
			end
			bus(cnt, 1'b0, 32'h0);
			check_word(v, (f == 3) ? 32'h6 : 32'h3);
		end
		end_of_test();
	end
endmodule : timer2_reload_compare_pwm_bench
